/* cns_node_status.sv */
// Overview of operation
// - Node address is high switch nibble above low switch nibble.
// - Only addresses 1 to 127 are valid; others are invalid.
// - Switches are sampled once after power-up reset, never again.
// - Rate positions 0..7 decode to 1000,800,500,250,125,100,50,20 kbit/s.
// - Stopped: single green flash; no PDO or SDO service.
// - Pre-operational: green toggles every 200 ms; no PDO exchange.
// - Operational: green solid on.
// - Red off without error; single red flash on warning or passive.
// - Guarding or heartbeat failure gives two red flashes.
// - Bus-off gives solid red and is held until power cycle.
// - Stack init failure, such as bad address, toggles red every 50 ms.
// - Controller code: 0 off, 2 active, 3 warning, 4 passive, 5 bus-off.
// - Slave code: 0 disabled, 1 initialising, 2 stopped.
`timescale 1ns/1ps
module cns_node_status #(
    parameter int PHASE_CYCLES = cns_pkg::PHASE_CYCLES,
    parameter int FAST_CYCLES  = cns_pkg::FAST_CYCLES
) (
    input  logic                     pclk,
    input  logic                     presetn,
    input  cns_pkg::cns_apb_req_type apb_req,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  cns_pkg::cns_switch_type  switches,
    output logic                     network_status_lamp_green,
    output logic                     network_status_lamp_red,
    output logic                     pdo_enable,
    output logic                     sdo_enable,
    output logic                     bus_termination_enable,
    output logic [6:0]               node_address
);
    import cns_pkg::*;
    function automatic logic [15:0] rate_kbps(input logic [3:0] pos);
        case (pos)
            4'h0: return 16'h03E8;
            4'h1: return 16'h0320;
            4'h2: return 16'h01F4;
            4'h3: return 16'h00FA;
            4'h4: return 16'h007D;
            4'h5: return 16'h0064;
            4'h6: return 16'h0032;
            4'h7: return 16'h0014;
            default: return 16'h0000;
        endcase
    endfunction
    cns_switch_type      sw_sync;
    cns_slave_state_type state_ff, nxt_state;
    logic [1:0]          settle_ff, term_ff, err_level_ff, red_count;
    logic [7:0]          addr_ff;
    logic [3:0]          rate_ff;
    logic [15:0]         kbps_ff;
    logic [2:0]          ctrl_code, slave_code, nmt_cmd;
    logic [TIMER_W-1:0]  phase_cnt_ff, fast_cnt_ff;
    logic [31:0]         prdata_ff;
    logic                sampled_ff, addr_ok_ff, rate_ok_ff, can_enable_ff;
    logic                guard_fail_ff, bus_off_ff, init_fail;
    logic                phase_tick, fast_tick, green_blink_ff, red_blink_ff;
    logic                green_flash, red_flash, green_ff, red_ff;
    logic                pdo_ff, sdo_ff, pready_ff, pslverr_ff;
    logic                setup_phase, wr_commit;
    cns_sync #(
        .WIDTH($bits(cns_switch_type))
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .async_in(switches),
        .sync_out(sw_sync)
    );
    // Wait for the synchroniser to fill before the one-time capture.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_ff  <= 2'h0;
            sampled_ff <= 1'b0;
        end else if (!sampled_ff) begin
            if (settle_ff == SETTLE_CYCLES) begin
                sampled_ff <= 1'b1;
            end else begin
                settle_ff <= 2'(settle_ff + 2'h1);
            end
        end
    end
    // Later switch moves are ignored until the next reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ff    <= 8'h00;
            addr_ok_ff <= 1'b0;
            rate_ff    <= 4'h0;
            rate_ok_ff <= 1'b0;
            kbps_ff    <= 16'h0000;
            term_ff    <= 2'h0;
        end else if (!sampled_ff && settle_ff == SETTLE_CYCLES) begin
            addr_ff    <= {sw_sync.addr_high, sw_sync.addr_low};
            addr_ok_ff <= {sw_sync.addr_high, sw_sync.addr_low} inside
                          {[ADDR_MIN:ADDR_MAX]};
            rate_ff    <= sw_sync.bitrate;
            rate_ok_ff <= sw_sync.bitrate <= RATE_MAX;
            kbps_ff    <= rate_kbps(sw_sync.bitrate);
            term_ff    <= sw_sync.termination;
        end
    end
    assign init_fail = sampled_ff && can_enable_ff &&
                       !(addr_ok_ff && rate_ok_ff);
    // Only both switches on (position 3) enables the terminator.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_termination_enable <= 1'b0;
        end else begin
            bus_termination_enable <= sampled_ff && (term_ff == 2'h3);
        end
    end
    assign node_address = addr_ff[6:0];
    // APB: zero wait states, answer in the first access cycle.
    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign wr_commit   = apb_req.psel && apb_req.penable && pready_ff &&
                         apb_req.pwrite;
    assign nmt_cmd     = apb_req.pwdata[CTRL_NMT_LSB +: 3];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            can_enable_ff <= CTRL_RESET[CTRL_ENABLE_BIT];
        end else if (wr_commit && apb_req.paddr == CTRL_OFFSET) begin
            can_enable_ff <= apb_req.pwdata[CTRL_ENABLE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_level_ff  <= ERR_RESET[ERR_LEVEL_LSB +: 2];
            guard_fail_ff <= ERR_RESET[ERR_GUARD_BIT];
        end else if (wr_commit && apb_req.paddr == ERR_OFFSET) begin
            err_level_ff  <= apb_req.pwdata[ERR_LEVEL_LSB +: 2];
            guard_fail_ff <= apb_req.pwdata[ERR_GUARD_BIT];
        end
    end
    // Bus-off is sticky; only a reset (power cycle) leaves it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_off_ff <= 1'b0;
        end else if (can_enable_ff && err_level_ff == LVL_BUSOFF) begin
            bus_off_ff <= 1'b1;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_DISABLED: begin
                if (can_enable_ff && sampled_ff) begin
                    nxt_state = ST_INIT;
                end
            end
            ST_INIT: begin
                if (!init_fail) begin
                    nxt_state = ST_PREOP;
                end
            end
            default: begin
                if (wr_commit && apb_req.paddr == CTRL_OFFSET) begin
                    if (nmt_cmd == SLV_CODE_STOPPED) begin
                        nxt_state = ST_STOPPED;
                    end else if (nmt_cmd == SLV_CODE_PREOP) begin
                        nxt_state = ST_PREOP;
                    end else if (nmt_cmd == SLV_CODE_OPER) begin
                        nxt_state = ST_OPER;
                    end
                end
            end
        endcase
        if (!can_enable_ff) begin
            nxt_state = ST_DISABLED;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_DISABLED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_comb begin
        slave_code = SLV_CODE_DISABLED;
        case (state_ff)
            ST_INIT:    slave_code = SLV_CODE_INIT;
            ST_STOPPED: slave_code = SLV_CODE_STOPPED;
            ST_PREOP:   slave_code = SLV_CODE_PREOP;
            ST_OPER:    slave_code = SLV_CODE_OPER;
        endcase
    end
    // Reserved code 1 is never produced.
    always_comb begin
        if (!can_enable_ff) begin
            ctrl_code = CTRL_CODE_DISABLED;
        end else if (bus_off_ff) begin
            ctrl_code = CTRL_CODE_BUSOFF;
        end else if (err_level_ff == LVL_PASSIVE) begin
            ctrl_code = CTRL_CODE_PASSIVE;
        end else if (err_level_ff == LVL_WARNING) begin
            ctrl_code = CTRL_CODE_WARNING;
        end else begin
            ctrl_code = CTRL_CODE_ACTIVE;
        end
    end
    // Free-running phase timers shared by all lamp patterns.
    assign phase_tick = phase_cnt_ff == TIMER_W'(PHASE_CYCLES - 1);
    assign fast_tick  = fast_cnt_ff == TIMER_W'(FAST_CYCLES - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_cnt_ff   <= '0;
            green_blink_ff <= 1'b0;
        end else if (phase_tick) begin
            phase_cnt_ff   <= '0;
            green_blink_ff <= !green_blink_ff;
        end else begin
            phase_cnt_ff   <= TIMER_W'(phase_cnt_ff + 1'b1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_cnt_ff  <= '0;
            red_blink_ff <= 1'b0;
        end else if (fast_tick) begin
            fast_cnt_ff  <= '0;
            red_blink_ff <= !red_blink_ff;
        end else begin
            fast_cnt_ff  <= TIMER_W'(fast_cnt_ff + 1'b1);
        end
    end
    assign red_count = guard_fail_ff ? 2'h2 :
                       (ctrl_code == CTRL_CODE_WARNING ||
                        ctrl_code == CTRL_CODE_PASSIVE) ? 2'h1 : 2'h0;
    cns_flash u_green_flash (
        .pclk      (pclk),
        .presetn   (presetn),
        .phase_tick(phase_tick),
        .flashes   (state_ff == ST_STOPPED ? 2'h1 : 2'h0),
        .lamp      (green_flash)
    );
    cns_flash u_red_flash (
        .pclk      (pclk),
        .presetn   (presetn),
        .phase_tick(phase_tick),
        .flashes   (red_count),
        .lamp      (red_flash)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            green_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_STOPPED: green_ff <= green_flash;
                ST_PREOP:   green_ff <= green_blink_ff;
                ST_OPER:    green_ff <= 1'b1;
                default:    green_ff <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            red_ff <= 1'b0;
        end else if (bus_off_ff) begin
            red_ff <= 1'b1;
        end else if (init_fail) begin
            red_ff <= red_blink_ff;
        end else begin
            red_ff <= red_flash;
        end
    end
    // Service gating follows the slave state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pdo_ff <= 1'b0;
            sdo_ff <= 1'b0;
        end else begin
            pdo_ff <= state_ff == ST_OPER;
            sdo_ff <= state_ff == ST_OPER || state_ff == ST_PREOP;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup_phase;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            if (setup_phase) begin
                if (apb_req.paddr == CFG_OFFSET) begin
                    prdata_ff[CFG_ADDR_LSB +: 7]  <= addr_ff[6:0];
                    prdata_ff[CFG_ADDR_OK_BIT]    <= addr_ok_ff;
                    prdata_ff[CFG_RATE_LSB +: 4]  <= rate_ff;
                    prdata_ff[CFG_RATE_OK_BIT]    <= rate_ok_ff;
                    prdata_ff[CFG_TERM_BIT]       <= term_ff == 2'h3;
                    prdata_ff[CFG_TERM_BAD]       <= ^term_ff;
                    prdata_ff[CFG_KBPS_LSB +: 16] <= kbps_ff;
                end else if (apb_req.paddr == CTRL_OFFSET) begin
                    prdata_ff[CTRL_ENABLE_BIT]   <= can_enable_ff;
                    prdata_ff[CTRL_NMT_LSB +: 3] <= slave_code;
                end else if (apb_req.paddr == ERR_OFFSET) begin
                    prdata_ff[ERR_LEVEL_LSB +: 2] <= err_level_ff;
                    prdata_ff[ERR_GUARD_BIT]      <= guard_fail_ff;
                end else if (apb_req.paddr == STAT_OFFSET) begin
                    prdata_ff[STAT_CTRL_LSB +: 3]  <= ctrl_code;
                    prdata_ff[STAT_SLAVE_LSB +: 3] <= slave_code;
                    prdata_ff[STAT_GREEN_BIT]      <= green_ff;
                    prdata_ff[STAT_RED_BIT]        <= red_ff;
                    prdata_ff[STAT_BOFF_BIT]       <= bus_off_ff;
                    prdata_ff[STAT_IFAIL_BIT]      <= init_fail;
                    prdata_ff[STAT_PDO_BIT]        <= pdo_ff;
                    prdata_ff[STAT_SDO_BIT]        <= sdo_ff;
                end else begin
                    pslverr_ff <= 1'b1;
                end
            end
        end
    end
    assign prdata                    = prdata_ff;
    assign pready                    = pready_ff;
    assign pslverr                   = pslverr_ff;
    assign network_status_lamp_green = green_ff;
    assign network_status_lamp_red   = red_ff;
    assign pdo_enable                = pdo_ff;
    assign sdo_enable                = sdo_ff;
endmodule

/* cns_pkg.sv */
package cns_pkg;

    // APB register map, byte addresses of 32-bit words.
    localparam logic [7:0] CFG_OFFSET  = 8'h00;
    localparam logic [7:0] CTRL_OFFSET = 8'h04;
    localparam logic [7:0] ERR_OFFSET  = 8'h08;
    localparam logic [7:0] STAT_OFFSET = 8'h0C;

    // CFG fields (read only, frozen at power-up).
    localparam int CFG_ADDR_LSB    = 0;
    localparam int CFG_ADDR_OK_BIT = 7;
    localparam int CFG_RATE_LSB    = 8;
    localparam int CFG_RATE_OK_BIT = 12;
    localparam int CFG_TERM_BIT    = 13;
    localparam int CFG_TERM_BAD    = 14;
    localparam int CFG_KBPS_LSB    = 16;

    // CTRL fields.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_NMT_LSB    = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ERR fields.
    localparam int ERR_LEVEL_LSB  = 0;
    localparam int ERR_GUARD_BIT  = 4;
    localparam logic [31:0] ERR_RESET = 32'h0000_0000;

    // STAT fields.
    localparam int STAT_CTRL_LSB  = 0;
    localparam int STAT_SLAVE_LSB = 4;
    localparam int STAT_GREEN_BIT = 8;
    localparam int STAT_RED_BIT   = 9;
    localparam int STAT_BOFF_BIT  = 10;
    localparam int STAT_IFAIL_BIT = 11;
    localparam int STAT_PDO_BIT   = 12;
    localparam int STAT_SDO_BIT   = 13;

    // Node address and bit rate limits.
    localparam logic [7:0] ADDR_MIN = 8'h01;
    localparam logic [7:0] ADDR_MAX = 8'h7F;
    localparam logic [3:0] RATE_MAX = 4'h7;

    // Controller error level written by software.
    localparam logic [1:0] LVL_ACTIVE  = 2'h0;
    localparam logic [1:0] LVL_WARNING = 2'h1;
    localparam logic [1:0] LVL_PASSIVE = 2'h2;
    localparam logic [1:0] LVL_BUSOFF  = 2'h3;

    // Controller status codes.
    localparam logic [2:0] CTRL_CODE_DISABLED = 3'h0;
    localparam logic [2:0] CTRL_CODE_ACTIVE   = 3'h2;
    localparam logic [2:0] CTRL_CODE_WARNING  = 3'h3;
    localparam logic [2:0] CTRL_CODE_PASSIVE  = 3'h4;
    localparam logic [2:0] CTRL_CODE_BUSOFF   = 3'h5;

    // Slave state codes; codes 2 to 4 are also the NMT commands accepted in CTRL.
    localparam logic [2:0] SLV_CODE_DISABLED = 3'h0;
    localparam logic [2:0] SLV_CODE_INIT     = 3'h1;
    localparam logic [2:0] SLV_CODE_STOPPED  = 3'h2;
    localparam logic [2:0] SLV_CODE_PREOP    = 3'h3;
    localparam logic [2:0] SLV_CODE_OPER     = 3'h4;

    // Timing.
    localparam int CLK_FREQ_KHZ  = 100_000;
    localparam int PHASE_MS      = 200;
    localparam int FAST_MS       = 50;
    localparam int PAUSE_MS      = 1000;
    localparam int PHASE_CYCLES  = CLK_FREQ_KHZ * PHASE_MS;
    localparam int FAST_CYCLES   = CLK_FREQ_KHZ * FAST_MS;
    localparam int PAUSE_PHASES  = (PAUSE_MS + PHASE_MS - 1) / PHASE_MS;
    localparam int TIMER_W       = 25;
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cns_apb_req_type;

    typedef struct packed {
        logic [1:0] termination;
        logic [3:0] bitrate;
        logic [3:0] addr_high;
        logic [3:0] addr_low;
    } cns_switch_type;

    typedef enum logic [4:0] {
        ST_DISABLED = 5'b00001,
        ST_INIT     = 5'b00010,
        ST_STOPPED  = 5'b00100,
        ST_PREOP    = 5'b01000,
        ST_OPER     = 5'b10000
    } cns_slave_state_type;

endpackage

/* cns_sync.sv */
`timescale 1ns/1ps
module cns_sync #(
    parameter int WIDTH = 14
) (
    input  logic             pclk,
    input  logic             presetn,
    input  logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

/* cns_flash.sv */
`timescale 1ns/1ps
module cns_flash
    import cns_pkg::*;
(
    input  logic       pclk,
    input  logic       presetn,
    input  logic       phase_tick,
    input  logic [1:0] flashes,
    output logic       lamp
);
    logic [3:0] phase_ff;
    logic [1:0] count_ff;
    logic       lamp_ff;
    logic [3:0] burst;
    logic [3:0] period;

    assign burst  = {1'b0, flashes, 1'b0};
    assign period = 4'(burst + 4'(PAUSE_PHASES));

    // A change of pattern restarts the group so no half group is shown.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= 4'h0;
            count_ff <= 2'h0;
        end else if (flashes != count_ff) begin
            phase_ff <= 4'h0;
            count_ff <= flashes;
        end else if (phase_tick) begin
            if (phase_ff == 4'(period - 4'h1)) begin
                phase_ff <= 4'h0;
            end else begin
                phase_ff <= 4'(phase_ff + 4'h1);
            end
        end
    end

    // Even burst phases are lit; whole phases of pause follow.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_ff <= 1'b0;
        end else begin
            lamp_ff <= (count_ff != 2'h0) && (count_ff == flashes) &&
                       (phase_ff < burst) && !phase_ff[0];
        end
    end

    assign lamp = lamp_ff;
endmodule

/* cns_switch_panel.sv */
`timescale 1ns/1ps
module cns_switch_panel
    import cns_pkg::*;
(
    input  logic                    pclk,
    input  cns_pkg::cns_switch_type setting,
    output cns_pkg::cns_switch_type switches
);
    cns_switch_type pos = '0;

    // A turn lands one clock later as a clean step, never mid-bounce.
    always @(posedge pclk)
        pos <= setting;
    assign switches = pos;
endmodule

/* cns_node_status_chk.sv */
`timescale 1ns/1ps
module cns_node_status_chk
    import cns_pkg::*;
#(
    parameter int PHASE_CYCLES = 8
) (
    input logic                     pclk,
    input logic                     presetn,
    input cns_pkg::cns_apb_req_type apb_req,
    input logic                     pready,
    input cns_pkg::cns_switch_type  switches,
    input logic                     network_status_lamp_green,
    input logic                     network_status_lamp_red,
    input logic                     pdo_enable,
    input logic                     sdo_enable,
    input logic                     bus_termination_enable,
    input logic [6:0]               node_address
);
    logic       grn_ff;
    logic [2:0] up_ff;
    logic [2:0] boff_ff;
    logic [7:0] gap_ff;
    logic [7:0] pre_ff;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_ff  <= 3'h0;
            grn_ff <= 1'b0;
            gap_ff <= 8'h00;
            pre_ff <= 8'h00;
        end else begin
            grn_ff <= network_status_lamp_green;
            if (up_ff != 3'h7)
                up_ff <= up_ff + 3'h1;
            if (grn_ff != network_status_lamp_green)
                gap_ff <= 8'h00;
            else if (gap_ff != 8'hFF)
                gap_ff <= gap_ff + 8'h01;
            if (!sdo_enable || pdo_enable)
                pre_ff <= 8'h00;
            else if (pre_ff != 8'hFF)
                pre_ff <= pre_ff + 8'h01;
        end
    end

    // Bus-off is sticky; later writes of other levels do not restart this.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            boff_ff <= 3'h0;
        else if (pready && apb_req.pwrite && apb_req.paddr == ERR_OFFSET
                 && apb_req.pwdata[1:0] == LVL_BUSOFF)
            boff_ff <= 3'h1;
        else if (boff_ff != 3'h0 && boff_ff != 3'h7)
            boff_ff <= boff_ff + 3'h1;
    end

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_ready_setup: assert property (apb_req.psel && !apb_req.penable
        |=> pready) else $error("no answer after setup");
    a_addr_capture: assert property (up_ff == 3'h6 |=>
        node_address == {switches.addr_high[2:0], switches.addr_low})
        else $error("bad node address");
    a_cfg_frozen: assert property (up_ff == 3'h7 |->
        $stable(node_address) && $stable(bus_termination_enable))
        else $error("capture moved");
    a_pdo_sdo: assert property (pdo_enable |-> sdo_enable)
        else $error("pdo without sdo");
    a_oper_green: assert property (pdo_enable [*4] |->
        network_status_lamp_green) else $error("green not solid");
    a_preop_toggle: assert property (pre_ff > 3 * PHASE_CYCLES |->
        gap_ff <= PHASE_CYCLES) else $error("green too slow");
    a_busoff_solid: assert property (boff_ff == 3'h7 |->
        network_status_lamp_red) else $error("red not solid");

    c_oper: cover property (pdo_enable [*4]);
    c_preop: cover property (pre_ff > 3 * PHASE_CYCLES);
    c_busoff: cover property (boff_ff == 3'h7);
endmodule

bind cns_node_status cns_node_status_chk #(
    .PHASE_CYCLES(PHASE_CYCLES)
) cns_node_status_chk_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
    .switches(switches),
    .network_status_lamp_green(network_status_lamp_green),
    .network_status_lamp_red(network_status_lamp_red),
    .pdo_enable(pdo_enable), .sdo_enable(sdo_enable),
    .bus_termination_enable(bus_termination_enable),
    .node_address(node_address)
);

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import cns_pkg::*;
    localparam int PH = 8;
    localparam int FA = 4;
    typedef struct packed {
        logic        e;
        logic [31:0] m;
        logic [31:0] d;
    } cns_exp_type;
    logic            pclk;
    logic            presetn;
    cns_apb_req_type apb_req;
    cns_switch_type  setting;
    cns_switch_type  switches;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            grn;
    logic            red;
    logic            pdo;
    logic            sdo;
    logic            term;
    logic [6:0]      node_address;
    cns_exp_type     q[$];
    cns_exp_type     x;
    int              checks;
    int              err_total;
    int              c;
    logic [7:0]      ad;
    logic [31:0]     cfg;
    logic            ok;
    logic [1:0]      t;
    int              kbps[8] = '{1000, 800, 500, 250, 125, 100, 50, 20};
    logic [7:0]      adr[6] = '{8'h01, 8'h7F, 8'h00, 8'h80, 8'h2E, 8'hFF};

    cns_node_status #(.PHASE_CYCLES(PH), .FAST_CYCLES(FA))
        cns_node_status_inst (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .switches(switches),
        .network_status_lamp_green(grn), .network_status_lamp_red(red),
        .pdo_enable(pdo), .sdo_enable(sdo), .bus_termination_enable(term),
        .node_address(node_address));
    cns_switch_panel cns_switch_panel_inst (
        .pclk(pclk), .setting(setting), .switches(switches));

    always #5 pclk = ~pclk;

    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, m, input logic e);
        int n;
        q.push_back('{e, m, d});
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, w, a, w ? d : 32'h0};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        apb_req <= '0;
        if (n == 20) begin
            err_total++;
            results();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, m);
        apb(1'b0, a, d, m, 1'b0);
    endtask

    // Patterns restart on a change; let them settle first.
    task automatic edges(input int n, input logic r, output int k);
        logic last;
        repeat (6) @(posedge pclk);
        last = r ? red : grn;
        k = 0;
        repeat (n) begin
            @(posedge pclk);
            k += int'((r ? red : grn) && !last);
            last = r ? red : grn;
        end
    endtask

    task automatic power_up(input cns_switch_type s);
        @(posedge pclk);
        presetn <= 1'b0;
        setting <= s;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (presetn && pready && apb_req.psel && apb_req.penable) begin
            x = q.pop_front();
            chk("prdata", x.d & x.m, prdata & x.m);
            chk("pslverr", {31'h0, x.e}, {31'h0, pslverr});
        end
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        apb_req = '0;
        setting = '0;
        checks = 0;
        err_total = 0;
        void'($urandom(32'hDFCA9545));
        for (int i = 0; i < 8; i++) begin
            ad = (i < 6) ? adr[i] : 8'($urandom_range(127, 1));
            t = 2'($urandom());
            ok = ad != 8'h00 && ad <= 8'h7F;
            power_up({t, 4'(i), ad});
            cfg = {16'(kbps[i]), 1'b0, ^t, &t, 1'b1, 4'(i), ok, ad[6:0]};
            rd(CFG_OFFSET, cfg, '1);
            chk("node", {25'h0, ad[6:0]}, {25'h0, node_address});
            chk("term", {31'h0, &t}, {31'h0, term});
            wr(CTRL_OFFSET, 32'h1);
            repeat (4) @(posedge pclk);
            rd(STAT_OFFSET, {18'h0, ok, 1'b0, !ok, 5'h0, ok, 1'b1, 4'h2},
               32'hFFFFFCFF);
            if (!ok) begin
                edges(10 * FA, 1'b1, c);
                chk("red fast", 32'h5, c);
            end
            setting <= ~setting;
            repeat (6) @(posedge pclk);
            rd(CFG_OFFSET, cfg, '1);
        end
        wr(CTRL_OFFSET, 32'h41);
        edges(20, 1'b0, c);
        chk("oper", 32'h80000003, {grn, c[28:0], pdo, sdo});
        wr(ERR_OFFSET, 32'h11);
        edges(18 * PH, 1'b1, c);
        chk("red double", 32'h4, c);
        for (int lv = 1; lv < 3; lv++) begin
            wr(ERR_OFFSET, 32'(lv));
            rd(STAT_OFFSET, 32'(lv + 2), 32'h7);
            edges(14 * PH, 1'b1, c);
            chk("red single", 32'h2, c);
        end
        wr(ERR_OFFSET, 32'h0);
        edges(30, 1'b1, c);
        chk("red off", 32'h0, {red, c[30:0]});
        rd(STAT_OFFSET, 32'h2, 32'h7);
        wr(CTRL_OFFSET, 32'h21);
        edges(14 * PH, 1'b0, c);
        chk("stopped", 32'h2, {pdo, sdo, c[29:0]});
        rd(STAT_OFFSET, 32'h20, 32'h70);
        wr(CTRL_OFFSET, 32'h31);
        edges(10 * PH, 1'b0, c);
        chk("preop", 32'h40000005, {pdo, sdo, c[29:0]});
        wr(ERR_OFFSET, 32'h3);
        wr(ERR_OFFSET, 32'h0);
        edges(40, 1'b1, c);
        chk("busoff", 32'h80000000, {red, c[30:0]});
        rd(STAT_OFFSET, 32'h405, 32'h407);
        apb(1'b0, 8'h10, 32'h0, '1, 1'b1);
        results();
    end
endmodule
